// >>> design/bcpg_sync.sv
`timescale 1ns/10ps
`default_nettype none

module bcpg_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // Each bit passes two flip-flops; only the second stage is read.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      meta_nxt[i] = din[i];
      sync_nxt[i] = meta_r[i];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= meta_nxt[i];
        sync_r[i] <= sync_nxt[i];
      end
    end
  end

  assign dout = sync_r;

endmodule // bcpg_sync

`default_nettype wire

// >>> design/bcpg_top.sv
`timescale 1ns/10ps
`default_nettype none

module bcpg_top (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      hall_u_in,
  input  wire logic                      hall_v_in,
  input  wire logic                      hall_w_in,
  input  wire logic [bcpg_pkg::DEM_W-1:0] speed_demand,
  input  wire logic                      current_sense,
  input  wire logic                      undervolt_detect_level,
  input  wire logic                      undervolt_recover_level,
  output var  bcpg_pkg::bcpg_arms_t      arms_out,
  output var  logic                      tacho_out,
  output var  logic [bcpg_pkg::DEM_W-1:0] sawtooth_node,
  output var  logic                      osc_period_out
);

  logic [bcpg_pkg::SYNC_W-1:0] raw_in;
  logic [bcpg_pkg::SYNC_W-1:0] sync_out;
  logic [2:0]                  hall_s;
  logic                        oc_s;
  logic                        uvdet_s;
  logic                        uvrec_s;

  logic [bcpg_pkg::DEM_W-1:0]  saw_r;
  logic [bcpg_pkg::DEM_W-1:0]  saw_nxt;
  logic                        wrap;
  logic                        wrap_r;
  logic                        wrap_nxt;
  logic                        pwm;
  logic                        oc_r;
  logic                        oc_nxt;
  logic                        uv_r;
  logic                        uv_nxt;
  logic                        run_top;
  logic                        run_bot;
  bcpg_pkg::bcpg_arms_t        comm;
  bcpg_pkg::bcpg_arms_t        arms_r;
  bcpg_pkg::bcpg_arms_t        arms_nxt;
  logic                        tacho_r;
  logic                        tacho_nxt;

  always_comb begin
    raw_in                        = '0;
    raw_in[bcpg_pkg::SB_U]        = hall_u_in;
    raw_in[bcpg_pkg::SB_V]        = hall_v_in;
    raw_in[bcpg_pkg::SB_W]        = hall_w_in;
    raw_in[bcpg_pkg::SB_OC]       = current_sense;
    raw_in[bcpg_pkg::SB_UVDET]    = undervolt_detect_level;
    raw_in[bcpg_pkg::SB_UVREC]    = undervolt_recover_level;
  end

  bcpg_sync #(
    .W (bcpg_pkg::SYNC_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     (raw_in),
    .dout    (sync_out)
  );

  assign hall_s  = {sync_out[bcpg_pkg::SB_U], sync_out[bcpg_pkg::SB_V],
                    sync_out[bcpg_pkg::SB_W]};
  assign oc_s    = sync_out[bcpg_pkg::SB_OC];
  assign uvdet_s = sync_out[bcpg_pkg::SB_UVDET];
  assign uvrec_s = sync_out[bcpg_pkg::SB_UVREC];

  // Sawtooth oscillator; one wrap marks one oscillator period.
  always_comb begin
    wrap    = (saw_r == bcpg_pkg::RAMP_TOP_LEVEL);
    saw_nxt = wrap ? bcpg_pkg::RAMP_MIN_LEVEL
                   : saw_r + bcpg_pkg::RAMP_STEP;
    wrap_nxt = wrap;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      saw_r  <= bcpg_pkg::RAMP_MIN_LEVEL;
      wrap_r <= 1'b0;
    end else begin
      saw_r  <= saw_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  // Ramp spans minimum to maximum-1, so duty is 0% at or below minimum.
  assign pwm = (speed_demand > saw_r);

  // Protection latches; a new event wins over its clear.
  always_comb begin
    oc_nxt = oc_r;
    if (oc_s) begin
      oc_nxt = 1'b1;
    end else if (wrap) begin
      oc_nxt = 1'b0;
    end
    uv_nxt = uv_r;
    if (uvdet_s) begin
      uv_nxt = 1'b1;
    end else if (uvrec_s) begin
      uv_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_r <= 1'b0;
      uv_r <= 1'b0;
    end else begin
      oc_r <= oc_nxt;
      uv_r <= uv_nxt;
    end
  end

  // Commutation decode and output gating.
  always_comb begin
    comm = bcpg_pkg::ARMS_OFF;
    case (hall_s)
      bcpg_pkg::HALL_S1: begin
        comm.u_bot = 1'b1;
        comm.v_top = 1'b1;
      end
      bcpg_pkg::HALL_S2: begin
        comm.u_bot = 1'b1;
        comm.w_top = 1'b1;
      end
      bcpg_pkg::HALL_S3: begin
        comm.v_bot = 1'b1;
        comm.w_top = 1'b1;
      end
      bcpg_pkg::HALL_S4: begin
        comm.u_top = 1'b1;
        comm.v_bot = 1'b1;
      end
      bcpg_pkg::HALL_S5: begin
        comm.u_top = 1'b1;
        comm.w_bot = 1'b1;
      end
      bcpg_pkg::HALL_S6: begin
        comm.v_top = 1'b1;
        comm.w_bot = 1'b1;
      end
      default: begin
        comm = bcpg_pkg::ARMS_OFF;
      end
    endcase
    run_top = !uv_r && (speed_demand >= bcpg_pkg::SHUTOFF_LEVEL);
    run_bot = run_top && !oc_r && pwm
              && (speed_demand >= bcpg_pkg::RAMP_MIN_LEVEL);
    arms_nxt       = bcpg_pkg::ARMS_OFF;
    arms_nxt.u_top = comm.u_top && run_top;
    arms_nxt.v_top = comm.v_top && run_top;
    arms_nxt.w_top = comm.w_top && run_top;
    arms_nxt.u_bot = comm.u_bot && run_bot;
    arms_nxt.v_bot = comm.v_bot && run_bot;
    arms_nxt.w_bot = comm.w_bot && run_bot;
    tacho_nxt = (hall_s[2] && hall_s[1]) || (hall_s[1] && hall_s[0])
                || (hall_s[2] && hall_s[0]);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arms_r  <= bcpg_pkg::ARMS_OFF;
      tacho_r <= 1'b0;
    end else begin
      arms_r  <= arms_nxt;
      tacho_r <= tacho_nxt;
    end
  end

  assign arms_out       = arms_r;
  assign tacho_out      = tacho_r;
  assign sawtooth_node  = saw_r;
  assign osc_period_out = wrap_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_run_full;
    !uv_r && !oc_r && (speed_demand >= bcpg_pkg::RAMP_MAX_LEVEL);
  endsequence

  sequence s_no_bottom;
    !arms_r.u_bot && !arms_r.v_bot && !arms_r.w_bot;
  endsequence

  property p_decode_s1;
    s_run_full and (hall_s == bcpg_pkg::HALL_S1)
      |=> arms_r.u_bot && arms_r.v_top && !arms_r.u_top && !arms_r.v_bot
          && !arms_r.w_top && !arms_r.w_bot;
  endproperty
  a_decode_s1: assert property (p_decode_s1)
    else $error("Step one arms wrong.");

  property p_decode_s5;
    s_run_full and (hall_s == bcpg_pkg::HALL_S5)
      |=> arms_r.u_top && arms_r.w_bot && !arms_r.v_top && !arms_r.u_bot;
  endproperty
  a_decode_s5: assert property (p_decode_s5)
    else $error("Step five arms wrong.");

  property p_invalid_off;
    (hall_s == 3'h0 || hall_s == 3'h7) |=> arms_r == bcpg_pkg::ARMS_OFF;
  endproperty
  a_invalid_off: assert property (p_invalid_off)
    else $error("Invalid Hall pattern drove an arm.");

  property p_tacho;
    ##1 tacho_out == ($countones($past(hall_s)) >= 2);
  endproperty
  a_tacho: assert property (p_tacho)
    else $error("Tacho does not follow Hall majority.");

  property p_duty_zero;
    (speed_demand < bcpg_pkg::RAMP_MIN_LEVEL) |=> s_no_bottom;
  endproperty
  a_duty_zero: assert property (p_duty_zero)
    else $error("Bottom arm on below ramp minimum.");

  property p_chop_follows_saw;
    (!uv_r && !oc_r && (hall_s == bcpg_pkg::HALL_S3)
      && (speed_demand >= bcpg_pkg::RAMP_MIN_LEVEL))
      |=> arms_r.v_bot == $past(speed_demand > saw_r);
  endproperty
  a_chop_follows_saw: assert property (p_chop_follows_saw)
    else $error("Bottom chop does not match sawtooth compare.");

  property p_top_steady;
    (hall_s == bcpg_pkg::HALL_S2) && !uv_r
      && (speed_demand >= bcpg_pkg::SHUTOFF_LEVEL) |=> arms_r.w_top;
  endproperty
  a_top_steady: assert property (p_top_steady)
    else $error("Top arm chopped or lost during its step.");

  property p_oc_off;
    oc_s |=> oc_r ##1 s_no_bottom;
  endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("Bottom arm on during over-current.");

  property p_oc_retry;
    oc_r && !oc_s && wrap |=> !oc_r;
  endproperty
  a_oc_retry: assert property (p_oc_retry)
    else $error("Over-current not retried at period end.");

  property p_uv_off;
    uv_r |=> arms_r == bcpg_pkg::ARMS_OFF;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("Arm on during under-voltage.");

  property p_uv_hold;
    uv_r && !uvrec_s |=> uv_r;
  endproperty
  a_uv_hold: assert property (p_uv_hold)
    else $error("Under-voltage released without recovery.");

  property p_shutoff;
    (speed_demand < bcpg_pkg::SHUTOFF_LEVEL)
      |=> arms_r == bcpg_pkg::ARMS_OFF;
  endproperty
  a_shutoff: assert property (p_shutoff)
    else $error("Arm on below shut-off demand.");

  property p_sync_delay;
    ##2 hall_s == $past({hall_u_in, hall_v_in, hall_w_in}, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Hall inputs not delayed by two stages.");

endmodule // bcpg_top

`default_nettype wire

// >>> inc/bcpg_pkg.sv
package bcpg_pkg;

  // Speed demand and sawtooth word width.
  localparam int unsigned DEM_W = 8;

  // Ramp limits and shut-off threshold in demand units.
  localparam logic [7:0] RAMP_MIN_LEVEL = 8'h40;
  localparam logic [7:0] RAMP_MAX_LEVEL = 8'hC0;
  localparam logic [7:0] RAMP_TOP_LEVEL = RAMP_MAX_LEVEL - 8'h01;
  localparam logic [7:0] SHUTOFF_LEVEL  = 8'h20;
  localparam logic [7:0] RAMP_STEP      = 8'h01;

  // Hall patterns, ordered {u, v, w}.
  localparam logic [2:0] HALL_S1 = 3'h5;
  localparam logic [2:0] HALL_S2 = 3'h4;
  localparam logic [2:0] HALL_S3 = 3'h6;
  localparam logic [2:0] HALL_S4 = 3'h2;
  localparam logic [2:0] HALL_S5 = 3'h3;
  localparam logic [2:0] HALL_S6 = 3'h1;

  // Synchroniser width and bit positions.
  localparam int unsigned SYNC_W   = 6;
  localparam int unsigned SB_W     = 0;
  localparam int unsigned SB_V     = 1;
  localparam int unsigned SB_U     = 2;
  localparam int unsigned SB_OC    = 3;
  localparam int unsigned SB_UVDET = 4;
  localparam int unsigned SB_UVREC = 5;

  typedef struct packed {
    logic u_top;
    logic u_bot;
    logic v_top;
    logic v_bot;
    logic w_top;
    logic w_bot;
  } bcpg_arms_t;

  localparam bcpg_arms_t ARMS_OFF = '0;

endpackage

// >>> verification/bcpg_hall_model.sv
`timescale 1ns/10ps
`default_nettype none

module bcpg_hall_model (
  input  wire logic [2:0] pattern,
  output var  logic       hall_u_in,
  output var  logic       hall_v_in,
  output var  logic       hall_w_in
);
  // Three Hall sensors; the pattern is ordered {u, v, w}.
  always_comb begin
    hall_u_in = pattern[2];
    hall_v_in = pattern[1];
    hall_w_in = pattern[0];
  end
endmodule // bcpg_hall_model

`default_nettype wire

// >>> verification/tb_bcpg_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_bcpg_top;
  logic                 ref_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic [2:0]           pattern = 3'h0;
  logic                 hall_u_in;
  logic                 hall_v_in;
  logic                 hall_w_in;
  logic [7:0]           speed_demand = 8'h00;
  logic                 current_sense = 1'b0;
  logic                 uv_det = 1'b0;
  logic                 uv_rec = 1'b0;
  bcpg_pkg::bcpg_arms_t arms_out;
  logic                 tacho_out;
  logic                 osc_period_out;
  logic [7:0]           sawtooth_node;
  int                   fail_count = 0;
  int                   n_compared = 0;
  int                   cycles = 0;

  always #5 ref_clk = ~ref_clk;

  bcpg_hall_model bcpg_hall_model_inst (
    .pattern   (pattern),
    .hall_u_in (hall_u_in),
    .hall_v_in (hall_v_in),
    .hall_w_in (hall_w_in)
  );

  bcpg_top bcpg_top_inst (
    .ref_clk                 (ref_clk),
    .rst_n                   (rst_n),
    .hall_u_in               (hall_u_in),
    .hall_v_in               (hall_v_in),
    .hall_w_in               (hall_w_in),
    .speed_demand            (speed_demand),
    .current_sense           (current_sense),
    .undervolt_detect_level  (uv_det),
    .undervolt_recover_level (uv_rec),
    .arms_out                (arms_out),
    .tacho_out               (tacho_out),
    .sawtooth_node           (sawtooth_node),
    .osc_period_out          (osc_period_out)
  );

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Gate commands for each Hall step, all bottoms at full duty.
  function automatic logic [7:0] exp_arms(logic [2:0] p);
    case (p)
      3'h5: return 8'h18;
      3'h4: return 8'h12;
      3'h6: return 8'h06;
      3'h2: return 8'h24;
      3'h3: return 8'h21;
      3'h1: return 8'h09;
      default: return 8'h00;
    endcase
  endfunction

  task automatic t_decode();
    logic [7:0] prev;
    speed_demand = 8'hC0;
    cyc(4);
    for (int i = 0; i < 8; i++) begin
      prev = arms_out;
      pattern = i[2:0];
      cyc(2);
      check("arms early", arms_out, prev);
      cyc(1);
      check("arms", arms_out, exp_arms(i[2:0]));
      check("tacho", tacho_out, (i >= 3 && i != 4));
    end
    $display("decode test done");
  endtask

  task automatic t_pwm();
    logic [7:0] dem [4] = '{8'h40, 8'h80, 8'hC0, 8'hFF};
    logic [7:0] exp;
    int nb;
    int nt;
    int np;
    pattern = 3'h5;
    foreach (dem[i]) begin
      speed_demand = dem[i];
      exp = (dem[i] >= 8'hC0) ? 8'h80 : dem[i] - 8'h40;
      cyc(2);
      nb = 0;
      nt = 0;
      np = 0;
      repeat (128) begin
        cyc(1);
        nb += arms_out.u_bot;
        nt += arms_out.v_top;
        np += osc_period_out;
      end
      check("duty", nb[7:0], exp);
      check("top on", nt[7:0], 8'h80);
      check("osc pulses", np[7:0], 8'h01);
    end
    $display("pwm test done");
  endtask

  task automatic t_shut();
    logic [7:0] dem [3] = '{8'h1F, 8'h20, 8'h3F};
    logic [7:0] exp [3] = '{8'h00, 8'h08, 8'h08};
    pattern = 3'h5;
    foreach (dem[i]) begin
      speed_demand = dem[i];
      cyc(2);
      check("shutoff arms", arms_out, exp[i]);
    end
    $display("shutoff test done");
  endtask

  task automatic t_oc();
    int k;
    pattern = 3'h4;
    speed_demand = 8'hC0;
    cyc(4);
    current_sense = 1'b1;
    cyc(5);
    check("oc arms", arms_out, 8'h02);
    cyc(200);
    check("oc held", arms_out, 8'h02);
    for (k = 0; k < 200 && osc_period_out !== 1'b1; k++) cyc(1);
    current_sense = 1'b0;
    cyc(20);
    check("oc latched", arms_out, 8'h02);
    for (k = 0; k < 130 && arms_out !== 8'h12; k++) cyc(1);
    check("oc retry", arms_out, 8'h12);
    $display("overcurrent test done");
  endtask

  task automatic t_uv();
    uv_det = 1'b1;
    cyc(5);
    check("uv arms", arms_out, 8'h00);
    uv_det = 1'b0;
    cyc(10);
    check("uv held", arms_out, 8'h00);
    uv_rec = 1'b1;
    cyc(5);
    check("uv recover", arms_out, 8'h12);
    uv_rec = 1'b0;
    $display("undervoltage test done");
  endtask

  initial begin
    cyc(6);
    check("reset arms", arms_out, 8'h00);
    check("reset saw", sawtooth_node, 8'h40);
    rst_n = 1'b1;
    t_decode();
    t_pwm();
    t_shut();
    t_oc();
    t_uv();
    final_report();
  end
endmodule // tb_bcpg_top

`default_nettype wire
